// File: dabc_pkg.sv
// constants, operation codes and phase numbering shared by both ends of the data access bus
package dabc_pkg;
   // ***********************************************************
   // widths, depths and reset values
   // ***********************************************************
   localparam int unsigned DATA_W = 16;           // shared address/data lines
   localparam int unsigned OP_W = 4;              // operation code width
   localparam int unsigned CMD_W = OP_W + DATA_W; // queued command word
   localparam int unsigned FIFO_DEPTH = 16;       // command queue depth
   localparam int unsigned LOC_W = 11;            // location counter width
   localparam logic [LOC_W-1:0] LOC_RESET = 11'h001; // location after reset
   localparam int unsigned IRQ_W = 4;             // external interrupt inputs
   localparam int unsigned MEM_DEPTH = 16;        // target word store
   localparam int unsigned MEM_AW = 4;            // target word index width

   // ***********************************************************
   // timing: one instruction cycle is four phases of one ref_clk each
   // ***********************************************************
   localparam int unsigned CLK_PERIOD_NS = 40;    // ref_clk period
   localparam int unsigned PHASE_NS = 40;         // one phase
   localparam int unsigned PHASE_CYC = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] PH_1 = 2'h0;            // phase one
   localparam logic [1:0] PH_2 = 2'h1;            // phase two
   localparam logic [1:0] PH_3 = 2'h2;            // phase three
   localparam logic [1:0] PH_4 = 2'h3;            // phase four

   // ***********************************************************
   // microinstruction operations on the data access bus
   // ***********************************************************
   typedef enum logic [OP_W-1:0] {
      OP_NOP,          // no operation
      OP_READ,         // read address cycle
      OP_WRITE,        // write address cycle
      OP_READ_ACK,     // read_ack_op
      OP_WRITE_ACK,    // write_ack_op
      OP_OUT_BYTE,     // output_byte_op
      OP_OUT_WORD,     // output word
      OP_OUT_STATUS,   // output_status_op
      OP_IN_DATA,      // input, ends the read
      OP_IN_RMW,       // input, holds the frame for a later output
      OP_IN_STATUS,    // input without acknowledge
      OP_TEST_IRQ      // sample interrupt_inputs
   } dabc_op_t;
endpackage : dabc_pkg

// File: dabc_if.sv
// bus wires between the processor end and the addressed target end
`timescale 1ns/1ps
`default_nettype none
interface dabc_if;
   logic [15:0] dev_out;                    // processor drive value
   logic dev_oe;                            // processor drives the lines
   logic [15:0] tgt_out;                    // target drive value
   logic tgt_oe;                            // target drives the lines
   logic [15:0] shared_address_data_lines;  // resolved line level
   logic frame;                             // framing of one bus operation
   logic rd_strobe;                         // target may drive read data
   logic wr_strobe;                         // write data present
   logic write_or_byte_line;                // write cycle / byte data
   logic interrupt_ack_line;                // acknowledge cycle
   logic target_ack;                        // target acknowledge
   logic bus_request;                       // external bus request
   logic [3:0] interrupt_inputs;            // external interrupt lines

   // resolve the shared lines from the two enables, idle lines read low
   assign shared_address_data_lines = dev_oe ? dev_out : (tgt_oe ? tgt_out : 16'h0000);

   modport dev (
      output dev_out, dev_oe, frame, rd_strobe, wr_strobe,
      output write_or_byte_line, interrupt_ack_line,
      input shared_address_data_lines, target_ack, bus_request, interrupt_inputs
   );
   modport tgt (
      output tgt_out, tgt_oe, target_ack, bus_request, interrupt_inputs,
      input shared_address_data_lines, frame, rd_strobe, wr_strobe,
      input write_or_byte_line, interrupt_ack_line
   );
endinterface : dabc_if
`default_nettype wire

// File: dabc_dev.sv
// command fifo and processor end of the data access bus
`timescale 1ns/1ps
`default_nettype none

// ***********************************************************
// command queue
// ***********************************************************
module dabc_fifo #(
   parameter int unsigned WIDTH = 20,
   parameter int unsigned DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];   // storage
   logic [AW-1:0] wr_q;               // write index
   logic [AW-1:0] rd_q;               // read index
   logic [AW:0] cnt_q;                // fill level
   logic push;
   logic pop;

   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rd_q];

   // indices and fill level
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end

   // storage write
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule : dabc_fifo

// ***********************************************************
// processor end
// ***********************************************************
module dabc_dev (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire dabc_pkg::dabc_op_t cmd_op,
   input wire logic [15:0] cmd_arg,
   input wire logic run_permit,
   output logic [15:0] rdata_q,
   output logic rdata_valid_q,
   output logic [3:0] irq_seen_q,
   output logic [10:0] loc_q,
   output logic stalled_q,
   dabc_if.dev bus
);
   import dabc_pkg::*;

   logic [1:0] phase_q;               // current phase
   logic f_valid;                     // queue head present
   logic f_ready;                     // queue head taken
   logic [CMD_W-1:0] f_data;          // queue head
   dabc_op_t instruction_latch_q;     // fetched instruction
   logic [15:0] latch_arg_q;          // its register pair
   dabc_op_t microinstruction_register_q; // executing instruction
   logic [15:0] mir_arg_q;            // its register pair
   logic ack_s1_q, ack_s2_q;          // acknowledge synchroniser
   logic req_s1_q, req_s2_q;          // bus request synchroniser
   logic samp_ack_q, samp_req_q;      // phase three samples
   logic load_mir;                    // run permitted at phase one
   logic ok;                          // completion condition
   logic done;                        // instruction completes now
   logic is_addr, is_wr_addr, is_ack, is_out, is_in;
   logic [15:0] dal_out_q;            // line drive value
   logic dal_oe_q;                    // line drive enable
   logic addr_cyc_q;                  // address cycle in progress
   logic addr_write_q;                // that address is for a write
   logic addr_ack_q;                  // that address is an acknowledge
   logic out_cyc_q;                   // output data cycle in progress
   logic term_q;                      // end the frame at next phase two
   logic rd_drop_q;                   // drop read strobe at next phase two
   logic rd_arm_q;                    // raise read strobe at next phase two
   logic frame_q, interrupt_ack_line_q, rd_q, wr_q, wob_q;

   dabc_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) i_dabc_fifo (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .in_valid(cmd_valid),
      .in_ready(cmd_ready),
      .in_data({cmd_op, cmd_arg}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   // decode of the executing instruction
   assign is_addr = (microinstruction_register_q inside {OP_READ, OP_WRITE, OP_READ_ACK,
                                                          OP_WRITE_ACK});
   assign is_wr_addr = (microinstruction_register_q inside {OP_WRITE, OP_WRITE_ACK});
   assign is_ack = (microinstruction_register_q inside {OP_READ_ACK, OP_WRITE_ACK});
   assign is_out = (microinstruction_register_q inside {OP_OUT_BYTE, OP_OUT_WORD});
   assign is_in = (microinstruction_register_q inside {OP_IN_DATA, OP_IN_RMW, OP_IN_STATUS});
   assign load_mir = (phase_q == PH_1) && run_permit
                     && (microinstruction_register_q == OP_NOP);
   assign f_ready = (instruction_latch_q == OP_NOP) || load_mir;
   assign done = (phase_q == PH_4) && (microinstruction_register_q != OP_NOP) && ok;

   // completion condition from the phase three samples
   always_comb begin
      case (microinstruction_register_q)
         OP_READ, OP_WRITE, OP_READ_ACK, OP_WRITE_ACK: ok = !samp_ack_q && !samp_req_q;
         OP_OUT_BYTE, OP_OUT_WORD, OP_IN_DATA, OP_IN_RMW: ok = samp_ack_q;
         OP_OUT_STATUS, OP_IN_STATUS, OP_TEST_IRQ: ok = 1'b1;
         default: ok = 1'b0;
      endcase
   end

   // ***********************************************************
   // phase counter and input synchronisers
   // ***********************************************************
   // four-phase sequencing
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         phase_q <= PH_1;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   // two-stage synchronisers, then the phase three sample
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         samp_ack_q <= 1'b0;
         samp_req_q <= 1'b0;
      end else begin
         ack_s1_q <= bus.target_ack;
         ack_s2_q <= ack_s1_q;
         req_s1_q <= bus.bus_request;
         req_s2_q <= req_s1_q;
         if (phase_q == PH_3) begin
            samp_ack_q <= ack_s2_q;
            samp_req_q <= req_s2_q;
         end
      end
   end

   // ***********************************************************
   // instruction registers and location counter
   // ***********************************************************
   // fetch, execute, repeat while the condition fails
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         instruction_latch_q <= OP_NOP;
         latch_arg_q <= 16'h0000;
         microinstruction_register_q <= OP_NOP;
         mir_arg_q <= 16'h0000;
         loc_q <= LOC_RESET;
         stalled_q <= 1'b0;
      end else begin
         if (f_ready) begin
            // refill from the queue head, nop when empty
            instruction_latch_q <= f_valid ? dabc_op_t'(f_data[CMD_W-1:DATA_W]) : OP_NOP;
            latch_arg_q <= f_data[DATA_W-1:0];
         end
         if (load_mir) begin
            microinstruction_register_q <= instruction_latch_q;
            mir_arg_q <= latch_arg_q;
         end else if (done) begin
            microinstruction_register_q <= OP_NOP;
            loc_q <= loc_q + 11'h001;
         end
         if (phase_q == PH_4) begin
            // level until the instruction completes
            stalled_q <= (microinstruction_register_q != OP_NOP) && !ok;
         end
      end
   end

   // ***********************************************************
   // shared line drive
   // ***********************************************************
   // address or data from phase one of the cycle after completion
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dal_out_q <= 16'h0000;
         dal_oe_q <= 1'b0;
         addr_cyc_q <= 1'b0;
         addr_write_q <= 1'b0;
         addr_ack_q <= 1'b0;
         out_cyc_q <= 1'b0;
      end else if (phase_q == PH_4) begin
         if (done && (is_addr || is_out || microinstruction_register_q == OP_OUT_STATUS)) begin
            dal_out_q <= mir_arg_q;
            dal_oe_q <= 1'b1;
         end else begin
            dal_oe_q <= 1'b0;
         end
         addr_cyc_q <= done && is_addr;
         addr_write_q <= is_wr_addr;
         addr_ack_q <= is_ack;
         out_cyc_q <= done && is_out;
      end
   end

   // ***********************************************************
   // control strobes
   // ***********************************************************
   // frame, interrupt acknowledge and read strobe change at phase two
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         frame_q <= 1'b0;
         interrupt_ack_line_q <= 1'b0;
         rd_q <= 1'b0;
         term_q <= 1'b0;
         rd_drop_q <= 1'b0;
         rd_arm_q <= 1'b0;
      end else begin
         if (phase_q == PH_4) begin
            term_q <= done && (is_out || microinstruction_register_q == OP_IN_DATA);
            rd_drop_q <= done && (microinstruction_register_q inside {OP_IN_DATA, OP_IN_RMW});
            rd_arm_q <= addr_cyc_q && !addr_write_q;
         end
         if (phase_q == PH_1) begin
            if (addr_cyc_q) begin
               frame_q <= 1'b1;
               interrupt_ack_line_q <= addr_ack_q;
            end else if (term_q) begin
               frame_q <= 1'b0;
               interrupt_ack_line_q <= 1'b0;
            end
            if (rd_arm_q) begin
               rd_q <= 1'b1;
            end else if (rd_drop_q || term_q) begin
               rd_q <= 1'b0;
            end
         end
      end
   end

   // write strobe and write_or_byte_line
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= 1'b0;
         wob_q <= 1'b0;
      end else begin
         if (phase_q == PH_4) begin
            wr_q <= done && is_out;
            wob_q <= done && ((is_addr && is_wr_addr)
                              || microinstruction_register_q == OP_OUT_BYTE);
         end else if (phase_q == PH_3 && out_cyc_q) begin
            wr_q <= 1'b0;
         end
      end
   end

   // ***********************************************************
   // input capture and interrupt sampling
   // ***********************************************************
   // read data taken during phase four
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 16'h0000;
         rdata_valid_q <= 1'b0;
         irq_seen_q <= 4'h0;
      end else begin
         rdata_valid_q <= done && is_in;
         if (done && is_in) begin
            rdata_q <= bus.shared_address_data_lines;
         end
         if (done && microinstruction_register_q == OP_TEST_IRQ) begin
            irq_seen_q <= bus.interrupt_inputs;
         end
      end
   end

   assign bus.dev_out = dal_out_q;
   assign bus.dev_oe = dal_oe_q;
   assign bus.frame = frame_q;
   assign bus.interrupt_ack_line = interrupt_ack_line_q;
   assign bus.rd_strobe = rd_q;
   assign bus.wr_strobe = wr_q;
   assign bus.write_or_byte_line = wob_q;
endmodule : dabc_dev
`default_nettype wire

// File: dabc_tgt.sv
// addressed target end: word store, acknowledge and interrupt identity
`timescale 1ns/1ps
`default_nettype none
module dabc_tgt #(
   parameter logic [15:0] ID_CODE = 16'h00A5 // arbitrary identity value
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [3:0] irq_req,
   input wire logic dma_req,
   input wire logic ack_enable,
   output logic wr_valid_q,
   output logic [15:0] wr_addr_q,
   output logic [15:0] wr_data_q,
   output logic [15:0] ack_data_q,
   dabc_if.tgt bus
);
   import dabc_pkg::*;

   logic [15:0] mem_q [MEM_DEPTH];   // word store
   logic frame_d_q;                  // frame delayed for edge detect
   logic wr_d_q;                     // write strobe delayed
   logic sel_q;                      // selected by the current frame
   logic [15:0] sel_addr_q;          // latched address
   logic sel_write_q;                // latched write flag
   logic sel_interrupt_ack_line_q;                 // latched acknowledge flag
   logic ack_q;                      // acknowledge drive
   logic [15:0] out_q;               // read data drive
   logic oe_q;                       // read data enable
   logic we;                         // write data accepted now
   logic [MEM_AW-1:0] widx;          // word index of the address

   assign widx = sel_addr_q[MEM_AW:1];
   // a read frame takes data only when held open for a closing output
   assign we = bus.wr_strobe && !wr_d_q && sel_q;

   // ***********************************************************
   // selection and acknowledge
   // ***********************************************************
   // latch the address at frame rise, release with the frame
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         frame_d_q <= 1'b0;
         wr_d_q <= 1'b0;
         sel_q <= 1'b0;
         sel_addr_q <= 16'h0000;
         sel_write_q <= 1'b0;
         sel_interrupt_ack_line_q <= 1'b0;
         ack_q <= 1'b0;
      end else begin
         frame_d_q <= bus.frame;
         wr_d_q <= bus.wr_strobe;
         if (bus.frame && !frame_d_q) begin
            sel_q <= 1'b1;
            sel_addr_q <= bus.shared_address_data_lines;
            sel_write_q <= bus.write_or_byte_line;
            sel_interrupt_ack_line_q <= bus.interrupt_ack_line;
         end else if (!bus.frame) begin
            sel_q <= 1'b0;
         end
         // acknowledge once selected for a write or once the read strobe stands, dropped as soon as the frame falls;
         // kept after a held input so the closing output can complete
         ack_q <= bus.frame && sel_q && ack_enable
                  && (sel_write_q || bus.rd_strobe || ack_q);
      end
   end

   // ***********************************************************
   // read data and write capture
   // ***********************************************************
   // read data while the read strobe stands
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         out_q <= 16'h0000;
         oe_q <= 1'b0;
         wr_valid_q <= 1'b0;
         wr_addr_q <= 16'h0000;
         wr_data_q <= 16'h0000;
         ack_data_q <= 16'h0000;
      end else begin
         oe_q <= sel_q && !sel_write_q && bus.rd_strobe;
         out_q <= sel_interrupt_ack_line_q ? ID_CODE : mem_q[widx];
         wr_valid_q <= we;
         if (we) begin
            wr_addr_q <= sel_addr_q;
            wr_data_q <= bus.shared_address_data_lines;
            if (sel_interrupt_ack_line_q) begin
               ack_data_q <= bus.shared_address_data_lines;
            end
         end
      end
   end

   // per-entry store, byte half chosen by the low address bit
   for (genvar g = 0; g < MEM_DEPTH; g++) begin : g_mem
      always_ff @(posedge ref_clk or negedge resetn) begin
         if (!resetn) begin
            mem_q[g] <= 16'h0000;
         end else if (we && !sel_interrupt_ack_line_q && widx == MEM_AW'(g)) begin
            if (!bus.write_or_byte_line) begin
               mem_q[g] <= bus.shared_address_data_lines;
            end else if (sel_addr_q[0]) begin
               mem_q[g][15:8] <= bus.shared_address_data_lines[15:8];
            end else begin
               mem_q[g][7:0] <= bus.shared_address_data_lines[7:0];
            end
         end
      end
   end

   assign bus.tgt_out = out_q;
   assign bus.tgt_oe = oe_q;
   assign bus.target_ack = ack_q;
   assign bus.bus_request = dma_req;
   assign bus.interrupt_inputs = irq_req;
endmodule : dabc_tgt
`default_nettype wire

// File: dabc_assertions.sv
// wire-level checks on the data access bus between the two ends
`timescale 1ns/1ps
`default_nettype none
module dabc_assertions (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic dev_oe,
   input wire logic [15:0] shared_address_data_lines,
   input wire logic frame,
   input wire logic rd_strobe,
   input wire logic wr_strobe,
   input wire logic interrupt_ack_line
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // acknowledge flag lives only inside a frame
   property p_interrupt_ack_line_frame; interrupt_ack_line |-> frame; endproperty
   a_interrupt_ack_line_frame: assert property (p_interrupt_ack_line_frame) else $error("interrupt_ack_line off frame");
   property p_interrupt_ack_line_rise; $rose(interrupt_ack_line) |-> $rose(frame); endproperty
   a_interrupt_ack_line_rise: assert property (p_interrupt_ack_line_rise) else $error("interrupt_ack_line late");
   // data is on the lines when the write strobe rises, within the frame
   property p_wr_rise; $rose(wr_strobe) |-> dev_oe && frame; endproperty
   a_wr_rise: assert property (p_wr_rise) else $error("strobe no data");
   property p_wr_hold; $rose(wr_strobe) |-> dev_oe [*4]; endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("data short");
   // strobe leaves one phase ahead of the data
   property p_wr_drop; $fell(wr_strobe) |=> $fell(dev_oe); endproperty
   a_wr_drop: assert property (p_wr_drop) else $error("data drop");
   property p_rd_frame; rd_strobe |-> frame; endproperty
   a_rd_frame: assert property (p_rd_frame) else $error("rd off frame");
   property p_rd_late; $rose(rd_strobe) |-> $past(frame, 2); endproperty
   a_rd_late: assert property (p_rd_late) else $error("rd early");
   // address stays put while the frame opens
   property p_addr_hold;
      $rose(frame) |-> (dev_oe && $stable(shared_address_data_lines)) [*2];
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
   c_interrupt_ack_line: cover property ($rose(interrupt_ack_line));
   c_rd: cover property ($rose(rd_strobe));
   c_wr: cover property ($rose(wr_strobe));
endmodule : dabc_assertions
`default_nettype wire

// File: data_access_bus_control_tb.sv
// self-checking bench joining processor end and target end
`timescale 1ns/1ps
`default_nettype none
module data_access_bus_control_tb;
   import dabc_pkg::*;
   localparam logic [15:0] TB_ID = 16'h5A3C; // arbitrary identity value
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   dabc_op_t cmd_op = OP_NOP;
   logic [15:0] cmd_arg = 16'h0000;
   logic run_permit = 1'b1;
   logic [15:0] rdata_q;
   logic rdata_valid_q;
   logic [3:0] irq_seen_q;
   logic [10:0] loc_q;
   logic [10:0] loc0;
   logic stalled_q;
   logic [3:0] irq_req = 4'h0;
   logic dma_req = 1'b0;
   logic ack_enable = 1'b1;
   logic [15:0] ack_data_q;
   int errors = 0;
   int n_checks = 0;
   int k;
   dabc_if bus_i ();
   dabc_dev i_dabc_dev (.ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_arg(cmd_arg), .run_permit(run_permit),
      .rdata_q(rdata_q), .rdata_valid_q(rdata_valid_q), .irq_seen_q(irq_seen_q),
      .loc_q(loc_q), .stalled_q(stalled_q), .bus(bus_i));
   dabc_tgt #(.ID_CODE(TB_ID)) i_dabc_tgt (.ref_clk(ref_clk), .resetn(resetn),
      .irq_req(irq_req), .dma_req(dma_req), .ack_enable(ack_enable), .wr_valid_q(),
      .wr_addr_q(), .wr_data_q(), .ack_data_q(ack_data_q), .bus(bus_i));
   dabc_assertions i_dabc_assertions (.ref_clk(ref_clk), .resetn(resetn),
      .dev_oe(bus_i.dev_oe), .shared_address_data_lines(bus_i.shared_address_data_lines),
      .frame(bus_i.frame), .rd_strobe(bus_i.rd_strobe), .wr_strobe(bus_i.wr_strobe),
      .interrupt_ack_line(bus_i.interrupt_ack_line));
   initial forever #20 ref_clk = ~ref_clk;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   // offer one command and hold it until the queue takes it
   task automatic send(input dabc_op_t op, input logic [15:0] arg);
      int i;
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_arg <= arg;
      @(posedge ref_clk);
      for (i = 0; i < 400 && cmd_ready !== 1'b1; i++) @(posedge ref_clk);
      if (cmd_ready !== 1'b1) errors++;
      if (cmd_ready !== 1'b1) wrap_up();
      cmd_valid <= 1'b0;
   endtask : send
   // wait for the captured word and compare it
   task automatic take(input logic [15:0] exp);
      int i;
      for (i = 0; i < 400 && rdata_valid_q !== 1'b1; i++) @(posedge ref_clk);
      if (rdata_valid_q !== 1'b1) errors++;
      if (rdata_valid_q !== 1'b1) wrap_up();
      chk(rdata_q, exp);
   endtask : take
   // address cycle, input, then compare the captured word
   task automatic rd(input dabc_op_t op, input logic [15:0] a, input logic [15:0] exp);
      send(op, a);
      send(OP_IN_DATA, 16'h0000);
      take(exp);
   endtask : rd
   initial begin
      repeat (8) @(posedge ref_clk);
      chk({5'h00, loc_q}, 16'h0001);
      chk({14'h0, bus_i.frame, bus_i.rd_strobe}, 16'h0000);
      resetn <= 1'b1;
      send(OP_WRITE, 16'h0006);
      send(OP_OUT_WORD, 16'h1234);
      rd(OP_READ, 16'h0006, 16'h1234);
      send(OP_WRITE, 16'h0007);
      send(OP_OUT_BYTE, 16'h3C3C);
      rd(OP_READ, 16'h0006, 16'h3C34);
      send(OP_READ, 16'h0006);
      send(OP_IN_RMW, 16'h0000);
      take(16'h3C34);
      repeat (2) @(posedge ref_clk);
      chk({14'h0, bus_i.frame, bus_i.rd_strobe}, 16'h0002);
      send(OP_OUT_WORD, 16'h5A5A);
      rd(OP_READ, 16'h0006, 16'h5A5A);
      $display("word and byte test done");
      ack_enable <= 1'b0;
      dma_req <= 1'b1;
      send(OP_WRITE, 16'h0008);
      send(OP_OUT_WORD, 16'hBEEF);
      repeat (40) @(posedge ref_clk);
      chk({15'h0, stalled_q}, 16'h0001);
      chk({14'h0, bus_i.frame, bus_i.dev_oe}, 16'h0000);
      dma_req <= 1'b0;
      repeat (40) @(posedge ref_clk);
      chk({15'h0, stalled_q}, 16'h0001);
      chk({14'h0, bus_i.frame, bus_i.wr_strobe}, 16'h0002);
      ack_enable <= 1'b1;
      rd(OP_READ, 16'h0008, 16'hBEEF);
      $display("stall test done");
      rd(OP_READ_ACK, 16'h0002, TB_ID);
      send(OP_WRITE_ACK, 16'h000A);
      send(OP_OUT_WORD, 16'h00C3);
      irq_req <= 4'hA;
      send(OP_TEST_IRQ, 16'h0000);
      rd(OP_READ, 16'h000A, 16'h0000);
      chk(ack_data_q, 16'h00C3);
      chk({12'h000, irq_seen_q}, 16'h000A);
      $display("acknowledge test done");
      send(OP_OUT_STATUS, 16'h0F0F);
      send(OP_IN_STATUS, 16'h0000);
      take(16'h0F0F);
      run_permit <= 1'b0;
      loc0 = loc_q;
      cmd_valid <= 1'b1;
      cmd_op <= OP_OUT_STATUS;
      cmd_arg <= 16'h0F0F;
      for (k = 0; k < 40 && cmd_ready === 1'b1; k++) @(posedge ref_clk);
      cmd_valid <= 1'b0;
      // k - 1 commands taken: the full queue plus the one in the latch
      chk({15'h0, k == FIFO_DEPTH + 2}, 16'h0001);
      chk({5'h00, loc_q}, {5'h00, loc0});
      run_permit <= 1'b1;
      repeat (40) @(posedge ref_clk);
      chk({13'h0, bus_i.frame, bus_i.wr_strobe, bus_i.dev_oe}, 16'h0001);
      chk(bus_i.shared_address_data_lines, 16'h0F0F);
      repeat (4 * 17 - 32) @(posedge ref_clk);
      chk({5'h00, loc_q}, {5'h00, loc0 + 11'(k - 1)});
      chk({15'h0, cmd_ready}, 16'h0001);
      $display("queue test done");
      wrap_up();
   end
endmodule : data_access_bus_control_tb
`default_nettype wire
